//--- rtl/mpgd_pkg.sv
// mpgd_pkg: register map, port layout and shared types for the multi-port gpio data block
// assumes a 32-bit apb slave with word-aligned registers
package mpgd_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_A_LATCH   = 8'h00;
  localparam logic [7:0] OFS_A_SENSE   = 8'h04;
  localparam logic [7:0] OFS_BH_LATCH  = 8'h08;
  localparam logic [7:0] OFS_BL_LATCH  = 8'h0C;
  localparam logic [7:0] OFS_BH_SENSE  = 8'h10;
  localparam logic [7:0] OFS_BL_SENSE  = 8'h14;
  localparam logic [7:0] OFS_C_LATCH   = 8'h18;
  localparam logic [7:0] OFS_C_SENSE   = 8'h1C;
  localparam logic [7:0] OFS_D_LATCH   = 8'h20;
  localparam logic [7:0] OFS_D_SENSE   = 8'h24;
  localparam logic [7:0] OFS_E_LATCH   = 8'h28;
  localparam logic [7:0] OFS_E_SENSE   = 8'h2C;
  localparam logic [7:0] OFS_F_LATCH   = 8'h30;
  localparam logic [7:0] OFS_F_SENSE   = 8'h34;
  localparam logic [7:0] OFS_G_INPUT   = 8'h38;
  localparam logic [7:0] OFS_H_LATCH   = 8'h3C;
  localparam logic [7:0] OFS_H_SENSE   = 8'h40;
  localparam logic [7:0] OFS_J_LATCH   = 8'h44;
  localparam logic [7:0] OFS_J_SENSE   = 8'h48;
  localparam logic [7:0] OFS_K_LATCH   = 8'h4C;
  localparam logic [7:0] OFS_K_SENSE   = 8'h50;

  // ------------------------------------------------------------------
  // flat pin vector layout (lsb position of each port)
  // ------------------------------------------------------------------
  localparam int NUM_PINS = 112;
  localparam int POS_A = 0;
  localparam int POS_B = 16;
  localparam int POS_C = 35;
  localparam int POS_D = 46;
  localparam int POS_E = 49;
  localparam int POS_F = 63;
  localparam int POS_G = 68;
  localparam int POS_H = 76;
  localparam int POS_J = 92;
  localparam int POS_K = 105;
  localparam int POS_END = 107;

  // ------------------------------------------------------------------
  // implemented bits per 16-bit register
  // ------------------------------------------------------------------
  localparam logic [15:0] MASK_A  = 16'hFFFF;
  localparam logic [15:0] MASK_BH = 16'h0007;
  localparam logic [15:0] MASK_BL = 16'hFFFF;
  localparam logic [15:0] MASK_C  = 16'h07FF;
  localparam logic [15:0] MASK_D  = 16'h0007;
  localparam logic [15:0] MASK_E  = 16'h3FFF;
  localparam logic [15:0] MASK_E_INONLY = 16'h1500;
  localparam logic [15:0] MASK_F  = 16'h001F;
  localparam logic [15:0] MASK_G  = 16'h00FF;
  localparam logic [15:0] MASK_H  = 16'hFFFF;
  localparam logic [15:0] MASK_J  = 16'h1FFF;
  localparam logic [15:0] MASK_K  = 16'h0003;

  // ------------------------------------------------------------------
  // reset values and fixed read value
  // ------------------------------------------------------------------
  localparam logic [15:0] LATCH_RESET    = 16'h0000;
  localparam logic        CONV_READ_BIT  = 1'b0;

  // ------------------------------------------------------------------
  // pin function select per pin
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPGD_FN_GPIO  = 2'b00,
    MPGD_FN_OTHER = 2'b01,
    MPGD_FN_CONV  = 2'b10,
    MPGD_FN_UDBUS = 2'b11
  } mpgd_fn_t;

  // ------------------------------------------------------------------
  // apb request and response carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mpgd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } mpgd_apb_rsp_t;

endpackage

//--- rtl/mpgd_top.sv
// mpgd_top: gpio data latches and pin-sense read paths for ten ports over apb
// assumes direction and function-select come from the pin function selector outside
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Contract
// - general output pins drive the written latch value
// - reading a general output bit returns the latch, not the pin
// - reading a general input bit returns the live pin level
// - writes to general input bits update the latch only
// - pin-sense registers are read-only and show pin levels for every function except the upper external data bus
// - port A has sixteen input pins on bits 15 to 0
// - port B has nineteen pins, high bits 2 to 0 and low bits 15 to 0
// - port C has eleven pins on bits 10 to 0
// - port D has three pins on bits 2 to 0
// - port E bits 13,11,9,7-0 are io; bits 12,10,8 are input only
// - port F has five pins on bits 4 to 0
// - port G data is read-only on eight pins; writes are dropped
// - port G general input only while both converters are halted; gpio-selected G pins still read the pin level while a converter runs
// - port G converter pins read as a fixed constant
// - port H has sixteen pins on bits 15 to 0
// - port J has thirteen pins on bits 12 to 0
// - port K has two pins on bits 1 and 0
// - upper external data bus pins show no level in either register
// - direction one makes a general pin output, zero input
module mpgd_top
  import mpgd_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // apb slave
  input  wire mpgd_pkg::mpgd_apb_req_t apb_req,
  output      mpgd_pkg::mpgd_apb_rsp_t apb_rsp,
  // pin function selector and converter state
  input  wire mpgd_pkg::mpgd_fn_t      pin_function_selector [mpgd_pkg::NUM_PINS],
  input  wire logic [mpgd_pkg::NUM_PINS-1:0] pin_direction,
  input  wire logic                    adc_halted,
  input  wire logic                    dac_halted,
  // pins
  input  wire logic [mpgd_pkg::NUM_PINS-1:0] pin_in,
  output      logic [mpgd_pkg::NUM_PINS-1:0] pin_out,
  output      logic [mpgd_pkg::NUM_PINS-1:0] pin_oe
);
  import mpgd_pkg::*;

  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("mpgd_top: SYNC_STAGES must be 2");
  end

  // ------------------------------------------------------------------
  // pin capability masks
  // ------------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_exists;
  logic [NUM_PINS-1:0] pin_can_drive;
  assign pin_exists    = {{(NUM_PINS-POS_END){1'b0}},
                          MASK_K[1:0], MASK_J[12:0], MASK_H, MASK_G[7:0], MASK_F[4:0],
                          MASK_E[13:0], MASK_D[2:0], MASK_C[10:0], MASK_BH[2:0], MASK_BL,
                          MASK_A};
  assign pin_can_drive = {{(NUM_PINS-POS_END){1'b0}},
                          MASK_K[1:0], MASK_J[12:0], MASK_H, 8'h00, MASK_F[4:0],
                          MASK_E[13:0] & ~MASK_E_INONLY[13:0], MASK_D[2:0], MASK_C[10:0],
                          MASK_BH[2:0], MASK_BL, 16'h0000};

  // ------------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------------
  logic [NUM_PINS-1:0] sync_meta;
  logic [NUM_PINS-1:0] pin_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= '0;
      pin_level <= '0;
    end else if (clk_en) begin
      sync_meta <= pin_in;
      pin_level <= sync_meta;
    end
  end

  // ------------------------------------------------------------------
  // per-pin function decode
  // ------------------------------------------------------------------
  logic [NUM_PINS-1:0] latch;
  logic [NUM_PINS-1:0] is_gp_out;
  logic [NUM_PINS-1:0] data_view;
  logic [NUM_PINS-1:0] sense_view;
  logic                conv_idle;
  assign conv_idle = adc_halted & dac_halted;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic gp_sel;
      logic is_g;
      logic hidden;
      assign is_g   = (gi >= POS_G) && (gi < POS_H);
      assign gp_sel = (pin_function_selector[gi] == MPGD_FN_GPIO) && (!is_g || conv_idle);
      assign hidden = (pin_function_selector[gi] == MPGD_FN_UDBUS);
      assign is_gp_out[gi] = gp_sel & pin_direction[gi] & pin_can_drive[gi];
      always_comb begin
        if (!pin_exists[gi] || hidden) begin
          data_view[gi] = 1'b0;
        end else if (is_g && pin_function_selector[gi] == MPGD_FN_CONV) begin
          data_view[gi] = CONV_READ_BIT;
        end else if (is_gp_out[gi]) begin
          data_view[gi] = latch[gi];
        end else begin
          data_view[gi] = pin_level[gi];
        end
      end
      assign sense_view[gi] = pin_exists[gi] & ~hidden & pin_level[gi];
    end
  endgenerate

  // ------------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (clk_en) begin
      pin_oe  <= is_gp_out;
      pin_out <= latch & is_gp_out;
    end
  end

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        hit;
  logic [15:0] rd16;
  assign acc = apb_req.psel & apb_req.penable & clk_en;
  assign wr  = acc & apb_req.pwrite;

  always_comb begin
    hit  = 1'b1;
    rd16 = 16'h0000;
    case (apb_req.paddr)
      OFS_A_LATCH:  rd16 = data_view[POS_A +: 16];
      OFS_A_SENSE:  rd16 = sense_view[POS_A +: 16];
      OFS_BH_LATCH: rd16 = {13'h0000, data_view[POS_B+16 +: 3]};
      OFS_BL_LATCH: rd16 = data_view[POS_B +: 16];
      OFS_BH_SENSE: rd16 = {13'h0000, sense_view[POS_B+16 +: 3]};
      OFS_BL_SENSE: rd16 = sense_view[POS_B +: 16];
      OFS_C_LATCH:  rd16 = {5'h00, data_view[POS_C +: 11]};
      OFS_C_SENSE:  rd16 = {5'h00, sense_view[POS_C +: 11]};
      OFS_D_LATCH:  rd16 = {13'h0000, data_view[POS_D +: 3]};
      OFS_D_SENSE:  rd16 = {13'h0000, sense_view[POS_D +: 3]};
      OFS_E_LATCH:  rd16 = {2'h0, data_view[POS_E +: 14]};
      OFS_E_SENSE:  rd16 = {2'h0, sense_view[POS_E +: 14]};
      OFS_F_LATCH:  rd16 = {11'h000, data_view[POS_F +: 5]};
      OFS_F_SENSE:  rd16 = {11'h000, sense_view[POS_F +: 5]};
      OFS_G_INPUT:  rd16 = {8'h00, data_view[POS_G +: 8]};
      OFS_H_LATCH:  rd16 = data_view[POS_H +: 16];
      OFS_H_SENSE:  rd16 = sense_view[POS_H +: 16];
      OFS_J_LATCH:  rd16 = {3'h0, data_view[POS_J +: 13]};
      OFS_J_SENSE:  rd16 = {3'h0, sense_view[POS_J +: 13]};
      OFS_K_LATCH:  rd16 = {14'h0000, data_view[POS_K +: 2]};
      OFS_K_SENSE:  rd16 = {14'h0000, sense_view[POS_K +: 2]};
      default:      hit  = 1'b0;
    endcase
  end

  logic [31:0] prdata_q;
  assign apb_rsp = '{pready: 1'b1, pslverr: acc & ~hit, prdata: prdata_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en && apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata_q <= {16'h0000, rd16};
    end
  end

  // ------------------------------------------------------------------
  // output latches
  // ------------------------------------------------------------------
  logic [NUM_PINS-1:0] wmask;
  logic [NUM_PINS-1:0] wval;
  always_comb begin
    wmask = '0;
    wval  = '0;
    case (apb_req.paddr)
      OFS_A_LATCH: begin
        wmask[POS_A +: 16]   = MASK_A;
        wval[POS_A +: 16]    = apb_req.pwdata[15:0];
      end
      OFS_BH_LATCH: begin
        wmask[POS_B+16 +: 3] = MASK_BH[2:0];
        wval[POS_B+16 +: 3]  = apb_req.pwdata[2:0];
      end
      OFS_BL_LATCH: begin
        wmask[POS_B +: 16]   = MASK_BL;
        wval[POS_B +: 16]    = apb_req.pwdata[15:0];
      end
      OFS_C_LATCH: begin
        wmask[POS_C +: 11]   = MASK_C[10:0];
        wval[POS_C +: 11]    = apb_req.pwdata[10:0];
      end
      OFS_D_LATCH: begin
        wmask[POS_D +: 3]    = MASK_D[2:0];
        wval[POS_D +: 3]     = apb_req.pwdata[2:0];
      end
      OFS_E_LATCH: begin
        wmask[POS_E +: 14]   = MASK_E[13:0];
        wval[POS_E +: 14]    = apb_req.pwdata[13:0];
      end
      OFS_F_LATCH: begin
        wmask[POS_F +: 5]    = MASK_F[4:0];
        wval[POS_F +: 5]     = apb_req.pwdata[4:0];
      end
      OFS_H_LATCH: begin
        wmask[POS_H +: 16]   = MASK_H;
        wval[POS_H +: 16]    = apb_req.pwdata[15:0];
      end
      OFS_J_LATCH: begin
        wmask[POS_J +: 13]   = MASK_J[12:0];
        wval[POS_J +: 13]    = apb_req.pwdata[12:0];
      end
      OFS_K_LATCH: begin
        wmask[POS_K +: 2]    = MASK_K[1:0];
        wval[POS_K +: 2]     = apb_req.pwdata[1:0];
      end
      default: begin
        wmask = '0;
        wval  = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= {7{LATCH_RESET}};
    end else if (wr) begin
      latch <= (latch & ~wmask) | (wval & wmask);
    end
  end

endmodule

//--- verification/mpgd_monitor.sv
// mpgd_monitor: port-level assertions for mpgd_top
// assumes one pclk domain with async active-low presetn
`timescale 1ns/1ps
module mpgd_monitor
  import mpgd_pkg::*;
(
  // clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          clk_en,
  // bus and pin control
  input wire mpgd_pkg::mpgd_apb_req_t       apb_req,
  input wire mpgd_pkg::mpgd_apb_rsp_t       apb_rsp,
  input wire mpgd_pkg::mpgd_fn_t            pin_function_selector [mpgd_pkg::NUM_PINS],
  input wire logic [mpgd_pkg::NUM_PINS-1:0] pin_direction,
  // pins
  input wire logic [mpgd_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [mpgd_pkg::NUM_PINS-1:0] pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_out;
    pin_function_selector[35] == MPGD_FN_GPIO && pin_direction[35] && clk_en |=> pin_oe[35];
  endproperty
  property p_in_quiet;
    pin_function_selector[35] == MPGD_FN_GPIO && !pin_direction[35] && clk_en |=> !pin_oe[35];
  endproperty
  property p_wr_out;
    apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en && apb_req.paddr == OFS_C_LATCH ##1 clk_en
      |=> !pin_oe[35] || pin_out[35] == $past(apb_req.pwdata[0], 2);
  endproperty
  property p_rd_hi;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && clk_en |=> apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  property p_ud_quiet;
    pin_function_selector[76] == MPGD_FN_UDBUS && clk_en |=> !pin_oe[76];
  endproperty
  property p_a_quiet; pin_oe[15:0] == 16'h0000; endproperty
  property p_g_quiet; pin_oe[75:68] == 8'h00; endproperty
  property p_e_quiet; !pin_oe[57] && !pin_oe[59] && !pin_oe[61]; endproperty
  a_oe_out: assert property (p_oe_out) else $error("output pin not driven");
  a_in_quiet: assert property (p_in_quiet) else $error("input pin driven");
  a_wr_out: assert property (p_wr_out) else $error("pin does not follow write");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
  a_ud_quiet: assert property (p_ud_quiet) else $error("data bus pin driven");
  a_a_quiet: assert property (p_a_quiet) else $error("port a driven");
  a_g_quiet: assert property (p_g_quiet) else $error("port g driven");
  a_e_quiet: assert property (p_e_quiet) else $error("port e input pin driven");
  c_write: cover property (apb_req.psel && apb_req.penable && apb_req.pwrite);
  c_read: cover property (apb_req.psel && apb_req.penable && !apb_req.pwrite);
  c_drive: cover property (pin_oe[35]);
endmodule
bind mpgd_top mpgd_monitor u_mpgd_monitor (.pclk, .presetn, .clk_en, .apb_req, .apb_rsp,
  .pin_function_selector, .pin_direction, .pin_out, .pin_oe);

//--- verification/mpgd_pins.sv
// mpgd_pins: board-side model of the port pins
// assumes the bench sets the external levels and may order a drive fight
`timescale 1ns/1ps
module mpgd_pins
  import mpgd_pkg::*;
(
  // from the block
  input  wire logic [mpgd_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [mpgd_pkg::NUM_PINS-1:0] pin_oe,
  // board side
  input  wire logic [mpgd_pkg::NUM_PINS-1:0] ext_level,
  input  wire logic                          fight,
  // to the block
  output      logic [mpgd_pkg::NUM_PINS-1:0] pin_in
);
  // a driven pin shows the block's level unless the board overpowers it
  assign pin_in = fight ? ext_level : (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- verification/mpgd_top_tb.sv
// mpgd_top_tb: self-checking bench for mpgd_top over apb
// assumes mpgd_pins on the pins and the bound monitor
`timescale 1ns/1ps
module mpgd_top_tb;
  import mpgd_pkg::*;
  logic                pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, fight = 1'b0, adc = 1'b1, dac = 1'b1;
  mpgd_apb_req_t       req = '0;
  mpgd_apb_rsp_t       rsp;
  mpgd_fn_t            sel [NUM_PINS];
  logic [NUM_PINS-1:0] dir = '0, pin_in, pin_out, pin_oe;
  logic [127:0]        ext = '0;
  logic [31:0]         rdv;
  logic                err;
  int                  err_count = 0, checks = 0;
  always #5 pclk = ~pclk;
  mpgd_top u_mpgd_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp),
    .pin_function_selector(sel), .pin_direction(dir), .adc_halted(adc), .dac_halted(dac),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  mpgd_pins u_mpgd_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext[NUM_PINS-1:0]), .fight(fight),
    .pin_in(pin_in));
  // ------------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (n >= 20) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [15:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdv, {16'h0000, exp});
  endtask
  task automatic t_map();
    logic [7:0] lo [11] = '{OFS_A_LATCH, OFS_BH_LATCH, OFS_BL_LATCH, OFS_C_LATCH, OFS_D_LATCH, OFS_E_LATCH,
      OFS_F_LATCH, OFS_G_INPUT, OFS_H_LATCH, OFS_J_LATCH, OFS_K_LATCH};
    logic [7:0] so [11] = '{OFS_A_SENSE, OFS_BH_SENSE, OFS_BL_SENSE, OFS_C_SENSE, OFS_D_SENSE, OFS_E_SENSE,
      OFS_F_SENSE, OFS_G_INPUT, OFS_H_SENSE, OFS_J_SENSE, OFS_K_SENSE};
    int ps [11] = '{POS_A, POS_B + 16, POS_B, POS_C, POS_D, POS_E, POS_F, POS_G, POS_H, POS_J, POS_K};
    logic [15:0] mk [11] = '{MASK_A, MASK_BH, MASK_BL, MASK_C, MASK_D, MASK_E, MASK_F, MASK_G, MASK_H,
      MASK_J, MASK_K};
    for (int p = 0; p < 2; p++) begin
      ext <= p ? ~ext : {8{16'hB7E9}};
      cyc(2);
      for (int i = 0; i < 11; i++) begin
        rd("latch", lo[i], ext[ps[i] +: 16] & mk[i]);
        rd("sense", so[i], ext[ps[i] +: 16] & mk[i]);
      end
    end
    ext[15:0] <= ~ext[15:0];
    rd("stale", OFS_A_SENSE, ext[15:0]);
    rd("synced", OFS_A_SENSE, ext[15:0]);
  endtask
  task automatic t_out();
    dir[45:35] <= 11'h7FF;
    apb(1'b1, OFS_C_LATCH, 32'hFFFF_F5A5);
    cyc(2);
    chk("c pins", {21'h0, pin_out[45:35]}, 32'h0000_05A5);
    chk("c oe", {21'h0, pin_oe[45:35]}, 32'h0000_07FF);
    fight <= 1'b1;
    cyc(2);
    rd("c latch", OFS_C_LATCH, 16'h05A5);
    rd("c sense", OFS_C_SENSE, {5'h00, ext[45:35]});
    fight <= 1'b0;
    clk_en <= 1'b0;
    apb(1'b1, OFS_C_LATCH, 32'h0000_0000);
    clk_en <= 1'b1;
    rd("c held", OFS_C_LATCH, 16'h05A5);
    apb(1'b1, OFS_C_SENSE, 32'h0000_0000);
    chk("ro err", {31'h0, err}, 32'h0000_0000);
    rd("c ro", OFS_C_LATCH, 16'h05A5);
    rd("unmapped", 8'h54, 16'h0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
  endtask
  task automatic t_in();
    apb(1'b1, OFS_H_LATCH, 32'h0000_1234);
    rd("h in", OFS_H_LATCH, ext[91:76]);
    chk("h oe", {16'h0, pin_oe[91:76]}, 32'h0000_0000);
    dir <= '1;
    apb(1'b1, OFS_A_LATCH, 32'h0000_FFFF);
    apb(1'b1, OFS_E_LATCH, 32'h0000_FFFF);
    apb(1'b1, OFS_G_INPUT, 32'h0000_FFFF);
    rd("h out", OFS_H_LATCH, 16'h1234);
    chk("h pins", {16'h0, pin_out[91:76]}, 32'h0000_1234);
    rd("g", OFS_G_INPUT, {8'h00, ext[75:68]});
    rd("e", OFS_E_LATCH, (MASK_E & ~MASK_E_INONLY) | ({2'b00, ext[62:49]} & MASK_E_INONLY));
  endtask
  task automatic t_fn();
    sel[68] <= MPGD_FN_CONV;
    sel[76] <= MPGD_FN_UDBUS;
    sel[77] <= MPGD_FN_OTHER;
    ext[77:76] <= 2'b11;
    cyc(2);
    rd("g conv", OFS_G_INPUT, {8'h00, ext[75:69], CONV_READ_BIT});
    rd("h ud", OFS_H_LATCH, 16'h1234 | {14'h0000, ext[77], 1'b0});
    rd("h ud sense", OFS_H_SENSE, 16'h1234 | {14'h0000, ext[77], 1'b0});
    adc <= 1'b0;
    cyc(2);
    rd("g busy", OFS_G_INPUT, {8'h00, ext[75:69], CONV_READ_BIT});
  endtask
  initial begin
    foreach (sel[i]) sel[i] <= MPGD_FN_GPIO;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_map();
    t_out();
    t_in();
    t_fn();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude();
  end
endmodule
